// *** dpp_defines.svh ***
// offsets and code values for the ping-pong receive channel
// assumes 12-bit byte addresses on the register port, 32-bit words
`ifndef DPP_DEFINES_SVH
`define DPP_DEFINES_SVH

// ==================================================================
// control table words of this channel
`define DPP_PRI_SRC_END   12'h080
`define DPP_PRI_DST_END   12'h084
`define DPP_PRI_CTL       12'h088
`define DPP_ALT_SRC_END   12'h280
`define DPP_ALT_DST_END   12'h284
`define DPP_ALT_CTL       12'h288

// ==================================================================
// channel attribute registers, one bit per channel
`define DPP_ENA_SET       12'h400
`define DPP_ENA_CLR       12'h404
`define DPP_ALT_SET       12'h408
`define DPP_ALT_CLR       12'h40C
`define DPP_PRIO_SET      12'h410
`define DPP_PRIO_CLR      12'h414
`define DPP_BURST_SET     12'h418
`define DPP_BURST_CLR     12'h41C
`define DPP_MASK_SET      12'h420
`define DPP_MASK_CLR      12'h424
`define DPP_CH_BIT        8

// ==================================================================
// control word codes and reset values
`define DPP_MODE_STOP     3'h0
`define DPP_MODE_BASIC    3'h1
`define DPP_MODE_PINGPONG 3'h3
`define DPP_INC_NONE      2'h3
`define DPP_WORD_RST      32'h00000000
`define DPP_MASK_RST      1'b1

`endif

// *** dpp_pkg.sv ***
// types shared by the ping-pong receive channel and its surroundings
// assumes dpp_defines.svh is the only source of numeric constants
package dpp_pkg;

    // ==================================================================
    // one control word, msb first
    typedef struct packed {
        logic [1:0] dst_inc;        // destination_increment
        logic [1:0] dst_size;       // destination_item_size
        logic [1:0] src_inc;        // source_increment
        logic [1:0] src_size;       // source_item_size
        logic [5:0] rsvd;
        logic [3:0] arb_size;       // arbitration_size
        logic [9:0] xfer_count;     // transfer_item_count
        logic       next_burst_only;
        logic [2:0] mode;           // transfer_mode
    } dpp_ctl_s;

    // one memory access toward the system bus
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [1:0]  size;
    } dpp_mem_s;

    typedef enum logic [1:0] {
        DPP_IDLE,
        DPP_READ,
        DPP_CAPT,
        DPP_WRITE
    } dpp_state_e;

endpackage

// *** dpp_channel.sv ***
// one dma receive channel in ping-pong mode with its control table
// assumes a same-clock peripheral and a memory with one-cycle reads
// Contract
// - primary structure at 0x080, alternate at 0x280
// - source end, destination end, control word at base, +4, +8
// - end pointers name the last address touched, inclusive
// - source increment 3 reads the same source address each item
// - increment and size code 0 mean bytes
// - arbitration size n moves two to the n items per burst
// - mode 3 selects ping-pong; bits 23:18 reserved zero
// - burst request moves a group, single request one item
// - burst-only bit set ignores single requests
// - request mask clear unmasks the channel
// - alternate select clear starts on the primary structure
// - priority set gives high priority, clear restores default
// - enable set bit at channel number enables the channel
// - enabled channel with request fills buffer A via primary
// - finished primary swaps to alternate without software
// - finished structure gets mode stopped
// - a buffer finishing signals an interrupt at the swap
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "dpp_defines.svh"

module dpp_channel (
    input  wire logic           i_ref_clk,      // system clock
    input  wire logic           i_reset,        // sync, active high
    input  wire logic [11:0]    i_addr,         // register byte address
    input  wire logic [31:0]    i_wdata,        // register write data
    input  wire logic           i_wr,           // register write strobe
    input  wire logic           i_rd,           // register read strobe
    output logic [31:0]         o_rdata,        // read data, next cycle
    input  wire logic           i_req_single,   // peripheral has data
    input  wire logic           i_req_burst,    // fifo at trigger level
    output logic                o_req_ack,      // group finished pulse
    output dpp_pkg::dpp_mem_s   o_mem,          // memory access
    input  wire logic [31:0]    i_mem_rdata,    // data one cycle after rd
    output logic                o_buf_done,     // buffer finished pulse
    output logic                o_buf_alt,      // 1 if buffer B finished
    output logic                o_chan_en,      // channel enable state
    output logic                o_high_prio     // priority state
);
    import dpp_pkg::*;

    // ==================================================================
    // storage
    logic [31:0]    src_q [2];
    logic [31:0]    dst_q [2];
    dpp_ctl_s       ctl_q [2];
    logic           alt_q;
    logic           en_q;
    logic           mask_q;
    logic           burst_only_q;
    dpp_state_e     state_q;
    logic [10:0]    grp_left_q;
    dpp_ctl_s       cur;
    logic           go;
    logic           finish;

    assign cur = ctl_q[alt_q];

    // an item ends the structure when its count was already zero
    assign finish = (state_q == DPP_CAPT) && (cur.xfer_count == 10'h000);

    // channel may start only when idle, armed and not stopped
    assign go = (state_q == DPP_IDLE) && en_q && !mask_q
        && (cur.mode != `DPP_MODE_STOP)
        && (i_req_burst || (i_req_single && !burst_only_q));

    // item address counts back from the inclusive end pointer
    function automatic logic [31:0] item_addr(
        input logic [31:0] endp,
        input logic [9:0]  cnt,
        input logic [1:0]  inc
    );
        logic [31:0] step;
        step = {22'h0, cnt} << inc;
        if (inc == `DPP_INC_NONE) begin
            item_addr = endp;
        end else begin
            item_addr = endp - step;
        end
    endfunction

    // ==================================================================
    // control table: software writes, hardware count and mode updates
    // hardware update wins so the count is never lost mid-transfer
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            for (int i = 0; i < 2; i++) begin
                src_q[i] <= `DPP_WORD_RST;
                dst_q[i] <= `DPP_WORD_RST;
                ctl_q[i] <= `DPP_WORD_RST;
            end
        end else begin
            if (i_wr) begin
                unique case (i_addr)
                    `DPP_PRI_SRC_END: src_q[0] <= i_wdata;
                    `DPP_PRI_DST_END: dst_q[0] <= i_wdata;
                    `DPP_PRI_CTL:     ctl_q[0] <= i_wdata;
                    `DPP_ALT_SRC_END: src_q[1] <= i_wdata;
                    `DPP_ALT_DST_END: dst_q[1] <= i_wdata;
                    `DPP_ALT_CTL:     ctl_q[1] <= i_wdata;
                    default: ;
                endcase
            end
            if (state_q == DPP_CAPT) begin
                if (finish) begin
                    ctl_q[alt_q].mode <= `DPP_MODE_STOP;
                end else begin
                    ctl_q[alt_q].xfer_count <=
                        cur.xfer_count - 10'h001;
                end
            end
        end
    end

    // ==================================================================
    // structure select: software picks, hardware swaps at buffer end
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            alt_q <= 1'b0;
        end else if (finish && cur.mode == `DPP_MODE_PINGPONG) begin
            alt_q <= !alt_q;
        end else if (i_wr && i_addr == `DPP_ALT_CLR
                     && i_wdata[`DPP_CH_BIT]) begin
            alt_q <= 1'b0;
        end else if (i_wr && i_addr == `DPP_ALT_SET
                     && i_wdata[`DPP_CH_BIT]) begin
            alt_q <= 1'b1;
        end
    end

    // ==================================================================
    // enable: set by software, dropped when a non ping-pong run ends
    // or when ping-pong swaps onto a structure software has not rearmed
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            en_q <= 1'b0;
        end else if (i_wr && i_addr == `DPP_ENA_SET
                     && i_wdata[`DPP_CH_BIT]) begin
            en_q <= 1'b1;
        end else if (finish && (cur.mode != `DPP_MODE_PINGPONG
                     || ctl_q[!alt_q].mode == `DPP_MODE_STOP)) begin
            en_q <= 1'b0;
        end else if (i_wr && i_addr == `DPP_ENA_CLR
                     && i_wdata[`DPP_CH_BIT]) begin
            en_q <= 1'b0;
        end
    end

    // ==================================================================
    // request mask, burst-only and priority attribute bits
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            mask_q       <= `DPP_MASK_RST;
            burst_only_q <= 1'b0;
            o_high_prio  <= 1'b0;
        end else if (i_wr && i_wdata[`DPP_CH_BIT]) begin
            unique case (i_addr)
                `DPP_MASK_CLR:  mask_q <= 1'b0;
                `DPP_MASK_SET:  mask_q <= 1'b1;
                `DPP_BURST_CLR: burst_only_q <= 1'b0;
                `DPP_BURST_SET: burst_only_q <= 1'b1;
                `DPP_PRIO_SET:  o_high_prio <= 1'b1;
                `DPP_PRIO_CLR:  o_high_prio <= 1'b0;
                default: ;
            endcase
        end
    end

    // ==================================================================
    // transfer engine: read peripheral, capture, write buffer
    // single channel, so priority only reports and never reorders
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_q    <= DPP_IDLE;
            grp_left_q <= 11'h000;
            o_mem      <= '0;
            o_req_ack  <= 1'b0;
            o_buf_done <= 1'b0;
            o_buf_alt  <= 1'b0;
        end else begin
            o_req_ack  <= 1'b0;
            o_buf_done <= 1'b0;
            unique case (state_q)
                DPP_IDLE: begin
                    if (go) begin
                        // burst moves 2**arb items, single one
                        grp_left_q <= i_req_burst
                            ? (11'h001 << cur.arb_size) - 11'h001
                            : 11'h000;
                        o_mem.rd   <= 1'b1;
                        o_mem.addr <= item_addr(src_q[alt_q],
                            cur.xfer_count, cur.src_inc);
                        o_mem.size <= cur.src_size;
                        state_q    <= DPP_READ;
                    end
                end
                DPP_READ: begin
                    o_mem.rd <= 1'b0;
                    state_q  <= DPP_CAPT;
                end
                DPP_CAPT: begin
                    o_mem.wr    <= 1'b1;
                    o_mem.wdata <= i_mem_rdata;
                    o_mem.addr  <= item_addr(dst_q[alt_q],
                        cur.xfer_count, cur.dst_inc);
                    o_mem.size  <= cur.dst_size;
                    if (finish) begin
                        o_buf_done <= 1'b1;
                        o_buf_alt  <= alt_q;
                        grp_left_q <= 11'h000;
                    end
                    state_q <= DPP_WRITE;
                end
                DPP_WRITE: begin
                    o_mem.wr <= 1'b0;
                    if (grp_left_q != 11'h000 && en_q) begin
                        grp_left_q <= grp_left_q - 11'h001;
                        o_mem.rd   <= 1'b1;
                        o_mem.addr <= item_addr(src_q[alt_q],
                            cur.xfer_count, cur.src_inc);
                        o_mem.size <= cur.src_size;
                        state_q    <= DPP_READ;
                    end else begin
                        o_req_ack <= 1'b1;
                        state_q   <= DPP_IDLE;
                    end
                end
            endcase
        end
    end

    // ==================================================================
    // register read port, one cycle latency, unmapped reads zero
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            o_rdata <= 32'h00000000;
            unique case (i_addr)
                `DPP_PRI_SRC_END: o_rdata <= src_q[0];
                `DPP_PRI_DST_END: o_rdata <= dst_q[0];
                `DPP_PRI_CTL:     o_rdata <= ctl_q[0];
                `DPP_ALT_SRC_END: o_rdata <= src_q[1];
                `DPP_ALT_DST_END: o_rdata <= dst_q[1];
                `DPP_ALT_CTL:     o_rdata <= ctl_q[1];
                `DPP_ENA_SET:     o_rdata[`DPP_CH_BIT] <= en_q;
                `DPP_ALT_SET:     o_rdata[`DPP_CH_BIT] <= alt_q;
                `DPP_PRIO_SET:    o_rdata[`DPP_CH_BIT] <= o_high_prio;
                `DPP_BURST_SET:   o_rdata[`DPP_CH_BIT] <= burst_only_q;
                `DPP_MASK_SET:    o_rdata[`DPP_CH_BIT] <= mask_q;
                default: ;
            endcase
        end
    end

    // mirror of enable for the outside
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_chan_en <= 1'b0;
        end else begin
            o_chan_en <= en_q;
        end
    end

endmodule

// *** dpp_channel_assertions.sv ***
// checker for the ping-pong receive channel, ports of dpp_channel only
// assumes one clock domain and the synchronous high reset
`timescale 1ns/1ns
module dpp_channel_assertions
    import dpp_pkg::*;
(
    input wire logic      i_ref_clk,    // clock
    input wire logic      i_reset,      // reset
    input wire logic      i_req_single, // single request
    input wire logic      i_req_burst,  // burst request
    input wire logic      o_req_ack,    // group done
    input wire dpp_mem_s  o_mem,        // memory access
    input wire logic      o_buf_done,   // buffer done
    input wire logic      o_buf_alt,    // finished buffer
    input wire logic      o_chan_en     // enable state
);
    // ==================================================================
    // helper counters: writes per group and next buffer to finish
    logic [3:0] wr_cnt_q;
    logic       exp_alt_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || o_req_ack) begin
            wr_cnt_q <= 4'h0;
        end else if (o_mem.wr) begin
            wr_cnt_q <= wr_cnt_q + 4'h1;
        end
    end
    // buffers must alternate, starting on the primary one
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            exp_alt_q <= 1'b0;
        end else if (o_buf_done) begin
            exp_alt_q <= ~exp_alt_q;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // ==================================================================
    AST_RD_THEN_WR: assert property (o_mem.rd |-> ##2 o_mem.wr)
        else $error("read not followed by write");
    AST_RD_CAUSE: assert property (o_mem.rd |->
        $past(i_req_single || i_req_burst) || $past(o_mem.wr))
        else $error("read without request");
    AST_ACK_AFTER_WR: assert property (o_req_ack |->
        $past(o_mem.wr) && !o_mem.rd) else $error("ack misplaced");
    AST_GROUP_LIMIT: assert property (o_mem.wr |-> wr_cnt_q < 4'h8)
        else $error("group longer than eight items");
    AST_SRC_FIXED: assert property ((o_mem.rd ##3 o_mem.rd) |->
        o_mem.addr == $past(o_mem.addr, 3)) else $error("source moved");
    AST_DST_STEP: assert property ((o_mem.wr ##3 o_mem.wr) |->
        o_mem.addr == $past(o_mem.addr, 3) + 32'h1)
        else $error("destination step wrong");
    AST_BYTE_SIZE: assert property (o_mem.wr |-> o_mem.size == 2'h0)
        else $error("item size not byte");
    AST_DONE_AT_WR: assert property (o_buf_done |-> o_mem.wr)
        else $error("done without final write");
    AST_ALT_SWAP: assert property (o_buf_done |-> o_buf_alt == exp_alt_q)
        else $error("buffers not alternating");
    AST_RD_NEEDS_EN: assert property (o_mem.rd |-> o_chan_en)
        else $error("read while disabled");
    COV_BURST: cover property (o_req_ack && wr_cnt_q == 4'h8);
    COV_SINGLE: cover property (o_req_ack && wr_cnt_q == 4'h1);
    COV_ALT_DONE: cover property (o_buf_done && o_buf_alt);
endmodule
bind dpp_channel dpp_channel_assertions u_chk (.i_ref_clk(i_ref_clk),
    .i_reset(i_reset), .i_req_single(i_req_single),
    .i_req_burst(i_req_burst), .o_req_ack(o_req_ack), .o_mem(o_mem),
    .o_buf_done(o_buf_done), .o_buf_alt(o_buf_alt), .o_chan_en(o_chan_en));

// *** dpp_periph_model.sv ***
// receive peripheral with a byte fifo behind one data register
// assumes the channel reads it at PER_ADDR with one-cycle read data
`timescale 1ns/1ns
module dpp_periph_model
    import dpp_pkg::*;
#(
    parameter logic [31:0] PER_ADDR = 32'h00004000 // data register
)(
    input  wire logic        i_ref_clk,    // clock
    input  wire logic        i_reset,      // reset
    input  wire logic        i_push,       // byte arrives
    input  wire logic [7:0]  i_push_data,  // arriving byte
    input  wire dpp_mem_s    i_mem,        // channel access
    input  wire logic        i_ack,        // group done
    output logic             o_req_single, // any data held
    output logic             o_req_burst,  // trigger level reached
    output logic [31:0]      o_rdata       // read data
);
    logic [7:0] fifo[$];
    int         cnt;
    logic       busy_q;
    // requests drop once served and rise again only after the ack
    assign o_req_single = !busy_q && cnt > 0;
    assign o_req_burst  = !busy_q && cnt >= 8;
    always @(posedge i_ref_clk) begin
        if (i_reset || i_ack) busy_q <= 1'b0;
        else if (i_mem.rd) busy_q <= 1'b1;
        if (i_push) fifo.push_back(i_push_data);
        // unread cycles show a changing pattern, never stale data
        if (i_mem.rd && i_mem.addr == PER_ADDR && fifo.size() > 0)
            o_rdata <= {24'h000000, fifo.pop_front()};
        else
            o_rdata <= ~o_rdata;
        // push and pop above already moved the queue, so its size is exact
        cnt <= fifo.size();
    end
    initial o_rdata = 32'h00000000;
    initial cnt = 0;
endmodule

// *** dpp_channel_tb.sv ***
// self-checking bench for the ping-pong receive channel
// assumes dpp_periph_model as data source; memory writes are observed
`timescale 1ns/1ns
`include "dpp_defines.svh"
module dpp_channel_tb;
    import dpp_pkg::*;
    localparam logic [31:0] PER   = 32'h00004000;
    localparam logic [31:0] BUF_A = 32'h00001000;
    localparam logic [31:0] BUF_B = 32'h00001040;
    localparam logic [31:0] CTL   = 32'h0C00C3F3;
    logic i_ref_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h00000000, o_rdata, i_mem_rdata;
    logic i_req_single, i_req_burst, o_req_ack, o_buf_done, o_buf_alt;
    logic o_chan_en, o_high_prio, push = 1'b0;
    logic [7:0] push_data = 8'h00, seed = 8'h5C;
    dpp_mem_s o_mem;
    logic [7:0] expq[$];
    int err_count = 0, tests_run = 0, nwr = 0, nrd = 0, nd = 0, idx = 0;
    logic alt = 1'b0;
    always #50 i_ref_clk = ~i_ref_clk;
    dpp_channel u_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_req_single(i_req_single),
        .i_req_burst(i_req_burst), .o_req_ack(o_req_ack), .o_mem(o_mem),
        .i_mem_rdata(i_mem_rdata), .o_buf_done(o_buf_done),
        .o_buf_alt(o_buf_alt), .o_chan_en(o_chan_en),
        .o_high_prio(o_high_prio));
    dpp_periph_model #(.PER_ADDR(PER)) u_per (.i_ref_clk(i_ref_clk),
        .i_reset(i_reset), .i_push(push), .i_push_data(push_data),
        .i_mem(o_mem), .i_ack(o_req_ack), .o_req_single(i_req_single),
        .o_req_burst(i_req_burst), .o_rdata(i_mem_rdata));
    // ==================================================================
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        @(posedge i_ref_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        @(negedge i_ref_clk);
        check(o_rdata & m, e);
    endtask
    // bytes arrive at a random rate, faster than items drain
    task automatic push_n(input int n);
        repeat (n) begin
            @(posedge i_ref_clk);
            seed = lfsr(seed);
            push <= 1'b1; push_data <= seed; expq.push_back(seed);
            @(posedge i_ref_clk);
            push <= 1'b0;
            if (seed[0]) @(posedge i_ref_clk);
        end
    endtask
    task automatic wait_wr(input int n);
        int k;
        k = 0;
        while (nwr < n && k < 4000) begin
            @(posedge i_ref_clk);
            k++;
        end
        check(32'(nwr), 32'(n));
    endtask
    // reference model: bytes in order into A, B, A at rising addresses
    always @(posedge i_ref_clk) if (!i_reset) begin
        if (o_buf_done) nd++;
        if (o_mem.rd) nrd++;
        if (o_mem.rd) check(o_mem.addr, PER);
        if (o_mem.wr) begin
            check(o_mem.addr, (alt ? BUF_B : BUF_A) + 32'(idx));
            check(o_mem.wdata, {24'h000000, expq.pop_front()});
            check(32'(o_buf_done), 32'(idx == 63));
            if (idx == 63) check(32'(o_buf_alt), 32'(alt));
            idx = (idx == 63) ? 0 : idx + 1;
            if (idx == 0) alt = ~alt;
            nwr++;
        end
    end
    // ==================================================================
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        rd_chk(`DPP_PRI_CTL, 32'hFFFFFFFF, `DPP_WORD_RST);
        rd_chk(`DPP_MASK_SET, 32'h00000100, 32'h00000100);
        rd_chk(12'h0FC, 32'hFFFFFFFF, 32'h00000000);
        wr_reg(`DPP_PRIO_SET, 32'h00000100);
        repeat (2) @(posedge i_ref_clk);
        check(32'(o_high_prio), 32'h1);
        wr_reg(`DPP_PRIO_CLR, 32'h00000100);
        repeat (2) @(posedge i_ref_clk);
        check(32'(o_high_prio), 32'h0);
        wr_reg(`DPP_ALT_SET, 32'h00000100);
        wr_reg(`DPP_ALT_CLR, 32'h00000100);
        rd_chk(`DPP_ALT_SET, 32'h00000100, 32'h00000000);
        for (int b = 0; b < 2; b++) begin
            wr_reg(b ? `DPP_ALT_SRC_END : `DPP_PRI_SRC_END, PER);
            wr_reg(b ? `DPP_ALT_DST_END : `DPP_PRI_DST_END,
                   (b ? BUF_B : BUF_A) + 32'h0000003F);
            wr_reg(b ? `DPP_ALT_CTL : `DPP_PRI_CTL, CTL);
        end
        rd_chk(`DPP_ALT_CTL, 32'hFFFFFFFF, CTL);
        wr_reg(`DPP_ENA_SET, 32'h00000100);
        push_n(3);
        repeat (20) @(posedge i_ref_clk);
        check(32'(o_chan_en), 32'h1);
        check(32'(nrd), 32'h0);
        wr_reg(`DPP_BURST_SET, 32'h00000100);
        wr_reg(`DPP_MASK_CLR, 32'h00000100);
        repeat (20) @(posedge i_ref_clk);
        check(32'(nrd), 32'h0);
        wr_reg(`DPP_BURST_CLR, 32'h00000100);
        push_n(61);
        wait_wr(64);
        rd_chk(`DPP_PRI_CTL, 32'h00000007, 32'(`DPP_MODE_STOP));
        wr_reg(`DPP_PRI_CTL, CTL);
        push_n(128);
        wait_wr(192);
        rd_chk(`DPP_ALT_CTL, 32'h00000007, 32'(`DPP_MODE_STOP));
        check(32'(o_chan_en), 32'h0);
        check(32'(nd), 32'h3);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        err_count++;
        summarize();
    end
endmodule
